// ### hw/apsf_regs.svh
// Contract
// - Mode field picks standby, wake, instant, full.
// - Bit 7 set selects fast host bus.
// - Bit 5 picks low or high wake threshold.
// - Settling is 462.5 ms or four output periods.
// - Bit 3 set bypasses the low-pass filter.
// - Bit 2 set bypasses the high-pass filter.
// - Start bit starts check; finished flag reads back.
// - Writing key 0x52 resets the whole device.
// - Port read pops one word, high byte first.
// - Two byte reads carry each popped word.
// - Continued port reads pop every third read.
// - Bursts at the port keep the pointer fixed.
// - Port reached by increment returns zero, no pop.
`ifndef APSF_REGS_SVH
`define APSF_REGS_SVH

`define APSF_POWER_CONTROL_ADDR  8'h3F
`define APSF_SELF_TEST_ADDR      8'h40
`define APSF_SOFT_RESET_ADDR     8'h41
`define APSF_FIFO_PORT_ADDR      8'h42

`define APSF_POWER_CONTROL_RESET 8'h00
`define APSF_POWER_CONTROL_MASK  8'hBF
`define APSF_PWR_HOST_FAST_BIT   7
`define APSF_PWR_WAKE_THR_BIT    5
`define APSF_PWR_SETTLE_SEL_BIT  4
`define APSF_PWR_LP_BYPASS_BIT   3
`define APSF_PWR_HP_BYPASS_BIT   2
`define APSF_PWR_MODE_MSB        1
`define APSF_PWR_MODE_LSB        0
`define APSF_ST_START_BIT        0
`define APSF_CHECK_FINISHED_FLAG_BIT         1

`define APSF_SOFT_RESET_KEY      8'h52

`define APSF_CLOCK_PERIOD_NS     10
`define APSF_SETTLE_LONG_US      462500
`define APSF_SETTLE_LONG_CYCLES  ((`APSF_SETTLE_LONG_US * 1000) / `APSF_CLOCK_PERIOD_NS)
`define APSF_SETTLE_ODR_PERIODS  4
`define APSF_FIFO_PHASES         3

`endif

// ### hw/apsf_pkg.sv
package apsf_pkg;

    typedef enum logic [1:0] {
        APSF_MODE_STANDBY,
        APSF_MODE_WAKE,
        APSF_MODE_INSTANT,
        APSF_MODE_FULL
    } apsf_mode_e;

    typedef enum logic [1:0] {
        APSF_SETTLE_OFF,
        APSF_SETTLE_RUN,
        APSF_SETTLE_DONE
    } apsf_settle_e;

    typedef logic [25:0] apsf_settle_cnt_t;

endpackage

// ### hw/apsf_settle_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "apsf_regs.svh"

module apsf_settle_timer #(
    parameter int unsigned LONG_CYCLES = `APSF_SETTLE_LONG_CYCLES
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_enable,
    input  wire logic i_start,
    input  wire logic i_short_select,
    input  wire logic i_odr_tick,
    output logic      o_settled
);

    apsf_pkg::apsf_settle_e     state_q;
    apsf_pkg::apsf_settle_cnt_t cnt_q;
    logic                       short_q;
    logic                       expire;

    // The short period counts output data ticks, so it tracks whatever rate is configured.
    assign expire = short_q
        ? (i_odr_tick && cnt_q == apsf_pkg::apsf_settle_cnt_t'(`APSF_SETTLE_ODR_PERIODS - 1))
        : (cnt_q == apsf_pkg::apsf_settle_cnt_t'(LONG_CYCLES - 1));

    always_ff @(posedge i_clock) begin
        if (i_rst || !i_enable) begin
            state_q <= apsf_pkg::APSF_SETTLE_OFF;
            cnt_q   <= '0;
            short_q <= 1'b0;
        end else if (i_start) begin
            state_q <= apsf_pkg::APSF_SETTLE_RUN;
            cnt_q   <= '0;
            short_q <= i_short_select;
        end else begin
            case (state_q)
                apsf_pkg::APSF_SETTLE_RUN: begin
                    if (expire) begin
                        state_q <= apsf_pkg::APSF_SETTLE_DONE;
                    end else if (!short_q || i_odr_tick) begin
                        cnt_q <= cnt_q + apsf_pkg::apsf_settle_cnt_t'(1);
                    end
                end
                apsf_pkg::APSF_SETTLE_DONE: begin
                    state_q <= apsf_pkg::APSF_SETTLE_DONE;
                end
                default: begin
                    state_q <= apsf_pkg::APSF_SETTLE_OFF;
                end
            endcase
        end
    end

    assign o_settled = (state_q == apsf_pkg::APSF_SETTLE_DONE);

endmodule // apsf_settle_timer
`default_nettype wire

// ### hw/apsf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "apsf_regs.svh"

module apsf_top #(
    parameter int unsigned SETTLE_LONG_CYCLES = `APSF_SETTLE_LONG_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_xfer_start,
    input  wire logic [7:0]  i_xfer_addr,
    input  wire logic        i_rd_strobe,
    input  wire logic        i_wr_strobe,
    input  wire logic [7:0]  i_wr_data,
    output logic      [7:0]  o_rd_data,
    output logic             o_rd_valid,
    output logic      [7:0]  o_addr_ptr,
    input  wire logic [15:0] i_fifo_word,
    output logic             o_fifo_pop,
    input  wire logic        i_check_complete,
    input  wire logic        i_odr_tick,
    output logic      [3:0]  o_mode_onehot,
    output logic             o_host_bus_fast,
    output logic             o_wake_threshold_high,
    output logic             o_lowpass_bypass,
    output logic             o_highpass_bypass,
    output logic             o_filter_settled,
    output logic             o_check_start,
    output logic             o_check_finished_flag,
    output logic             o_soft_reset
);

    logic                   soft_q;
    logic                   srst;
    logic [7:0]             power_q;
    logic                   check_start_q;
    logic                   check_done_q;
    logic [7:0]             ptr_q;
    logic                   ptr_direct_q;
    logic [1:0]             phase_q;
    logic [7:0]             word_lo_q;
    logic [7:0]             rd_data_q;
    logic                   rd_valid_q;
    logic [7:0]             rd_byte;
    logic                   fifo_direct;
    logic                   power_wr;
    logic                   self_test_wr;
    logic                   settle_enable;
    apsf_pkg::apsf_mode_e   mode;
    apsf_pkg::apsf_mode_e   next_mode;

    function automatic logic at_addr(input logic [7:0] ptr, input logic [7:0] addr);
        at_addr = (ptr == addr);
    endfunction

    // The key pulse resets every register below for one cycle; it is recomputed each cycle and falls once the key write ends.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= i_wr_strobe && at_addr(ptr_q, `APSF_SOFT_RESET_ADDR)
                && (i_wr_data == `APSF_SOFT_RESET_KEY);
        end
    end

    assign srst         = i_rst || soft_q;
    assign o_soft_reset = soft_q;

    assign fifo_direct  = at_addr(ptr_q, `APSF_FIFO_PORT_ADDR) && ptr_direct_q;
    assign power_wr     = i_wr_strobe && at_addr(ptr_q, `APSF_POWER_CONTROL_ADDR);
    assign self_test_wr = i_wr_strobe && at_addr(ptr_q, `APSF_SELF_TEST_ADDR);

    // A pointer aimed at the port stays put; an incremented arrival walks past it.
    always_ff @(posedge i_clock) begin
        if (srst) begin
            ptr_q        <= 8'h00;
            ptr_direct_q <= 1'b0;
        end else if (i_xfer_start) begin
            ptr_q        <= i_xfer_addr;
            ptr_direct_q <= 1'b1;
        end else if ((i_rd_strobe || i_wr_strobe) && !fifo_direct) begin
            ptr_q        <= ptr_q + 8'h01;
            ptr_direct_q <= 1'b0;
        end
    end

    assign o_addr_ptr = ptr_q;

    always_ff @(posedge i_clock) begin
        if (srst) begin
            power_q <= `APSF_POWER_CONTROL_RESET;
        end else if (power_wr) begin
            power_q <= i_wr_data & `APSF_POWER_CONTROL_MASK;
        end
    end

    assign mode      = apsf_pkg::apsf_mode_e'(power_q[`APSF_PWR_MODE_MSB:`APSF_PWR_MODE_LSB]);
    assign next_mode = apsf_pkg::apsf_mode_e'(i_wr_data[`APSF_PWR_MODE_MSB:`APSF_PWR_MODE_LSB]);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_mode
            assign o_mode_onehot[g] = (mode == apsf_pkg::apsf_mode_e'(2'(g)));
        end
    endgenerate

    assign o_host_bus_fast       = power_q[`APSF_PWR_HOST_FAST_BIT];
    assign o_wake_threshold_high = power_q[`APSF_PWR_WAKE_THR_BIT];
    assign o_lowpass_bypass      = power_q[`APSF_PWR_LP_BYPASS_BIT];
    assign o_highpass_bypass     = power_q[`APSF_PWR_HP_BYPASS_BIT];

    // A write into standby stops the timer on its own edge, so settled never shows in standby.
    assign settle_enable = power_wr ? (next_mode != apsf_pkg::APSF_MODE_STANDBY)
                                    : (mode != apsf_pkg::APSF_MODE_STANDBY);

    // Every power write into a measuring mode restarts settling, since filters may have changed.
    apsf_settle_timer #(
        .LONG_CYCLES (SETTLE_LONG_CYCLES)
    ) u_settle (
        .i_clock        (i_clock),
        .i_rst          (srst),
        .i_enable       (settle_enable),
        .i_start        (power_wr && next_mode != apsf_pkg::APSF_MODE_STANDBY),
        .i_short_select (i_wr_data[`APSF_PWR_SETTLE_SEL_BIT]),
        .i_odr_tick     (i_odr_tick),
        .o_settled      (o_filter_settled)
    );

    always_ff @(posedge i_clock) begin
        if (srst) begin
            check_start_q <= 1'b0;
        end else if (self_test_wr) begin
            check_start_q <= i_wr_data[`APSF_ST_START_BIT];
        end
    end

    // A completion in the same cycle as a write still lands in the flag.
    always_ff @(posedge i_clock) begin
        if (srst) begin
            check_done_q <= 1'b0;
        end else if (i_check_complete && check_start_q) begin
            check_done_q <= 1'b1;
        end else if (self_test_wr) begin
            check_done_q <= 1'b0;
        end
    end

    assign o_check_start         = check_start_q;
    assign o_check_finished_flag = check_done_q;

    // Phase 0 pops and sends the high byte, phase 1 the low byte, phase 2 a zero filler.
    always_ff @(posedge i_clock) begin
        if (srst || i_xfer_start) begin
            phase_q <= 2'h0;
        end else if (i_rd_strobe && fifo_direct) begin
            if (phase_q == 2'(`APSF_FIFO_PHASES - 1)) begin
                phase_q <= 2'h0;
            end else begin
                phase_q <= phase_q + 2'h1;
            end
        end
    end

    assign o_fifo_pop = i_rd_strobe && fifo_direct && (phase_q == 2'h0);

    always_ff @(posedge i_clock) begin
        if (srst) begin
            word_lo_q <= 8'h00;
        end else if (o_fifo_pop) begin
            word_lo_q <= i_fifo_word[7:0];
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (ptr_q)
            `APSF_POWER_CONTROL_ADDR: begin
                rd_byte = power_q & `APSF_POWER_CONTROL_MASK;
            end
            `APSF_SELF_TEST_ADDR: begin
                rd_byte = {6'h00, check_done_q, check_start_q};
            end
            `APSF_FIFO_PORT_ADDR: begin
                if (fifo_direct && phase_q == 2'h0) begin
                    rd_byte = i_fifo_word[15:8];
                end else if (fifo_direct && phase_q == 2'h1) begin
                    rd_byte = word_lo_q;
                end else begin
                    rd_byte = 8'h00;
                end
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (srst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_strobe;
            if (i_rd_strobe) begin
                rd_data_q <= rd_byte;
            end
        end
    end

    assign o_rd_data  = rd_data_q;
    assign o_rd_valid = rd_valid_q;

endmodule // apsf_top
`default_nettype wire

// ### dv/apsf_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module apsf_top_asserts (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_rd_strobe,
    input wire logic        i_wr_strobe,
    input wire logic [7:0]  i_wr_data,
    input wire logic [7:0]  o_rd_data,
    input wire logic        o_rd_valid,
    input wire logic [7:0]  o_addr_ptr,
    input wire logic [15:0] i_fifo_word,
    input wire logic        o_fifo_pop,
    input wire logic        i_check_complete,
    input wire logic [3:0]  o_mode_onehot,
    input wire logic        o_host_bus_fast,
    input wire logic        o_wake_threshold_high,
    input wire logic        o_lowpass_bypass,
    input wire logic        o_highpass_bypass,
    input wire logic        o_check_start,
    input wire logic        o_check_finished_flag,
    input wire logic        o_soft_reset
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // The soft reset cycle clears state, so no cause other than bad_key_a is judged in it.
    logic        pw;
    logic        rq;
    logic [7:0]  wd_q;
    logic [15:0] pop_w;
    assign pw = i_wr_strobe && o_addr_ptr == 8'h3F && !o_soft_reset;
    assign rq = i_rd_strobe && !o_soft_reset;
    always_ff @(posedge i_clock) wd_q <= i_wr_data;
    always_ff @(posedge i_clock) if (o_fifo_pop) pop_w <= i_fifo_word;
    sequence pop_rd;
        o_fifo_pop && rq ##1 rq;
    endsequence
    rd_answer_a: assert property (rq |=> o_rd_valid) else $error("read answer missing");
    mode_decode_a: assert property (pw |=> o_mode_onehot == 4'h1 << wd_q[1:0])
        else $error("mode decode wrong");
    fast_bit_a: assert property (pw |=> o_host_bus_fast == wd_q[7]) else $error("fast bit wrong");
    filter_bits_a: assert property (pw |=> {o_wake_threshold_high, o_lowpass_bypass,
        o_highpass_bypass} == {wd_q[5], wd_q[3:2]}) else $error("filter bits wrong");
    check_done_a: assert property (i_check_complete && o_check_start && !o_soft_reset
        |=> o_check_finished_flag) else $error("finished flag missing");
    key_reset_a: assert property (i_wr_strobe && o_addr_ptr == 8'h41 && i_wr_data == 8'h52
        && !o_soft_reset |=> o_soft_reset ##1 (o_addr_ptr == 8'h00 && o_mode_onehot == 4'h1))
        else $error("key reset missing");
    bad_key_a: assert property (i_wr_strobe && o_addr_ptr == 8'h41 && i_wr_data != 8'h52
        |=> !o_soft_reset) else $error("reset without key");
    fifo_head_a: assert property (rq && o_fifo_pop |=> o_rd_data == pop_w[15:8]
        && o_addr_ptr == 8'h42) else $error("head byte wrong");
    fifo_low_a: assert property (pop_rd |-> !o_fifo_pop ##1 o_rd_data == pop_w[7:0])
        else $error("low byte wrong");
    third_pop_a: assert property (pop_rd ##1 rq ##1 rq |-> o_fifo_pop) else $error("third pop missing");
    incr_zero_a: assert property (rq && o_addr_ptr == 8'h42 && !o_fifo_pop
        |=> o_addr_ptr != 8'h43 || o_rd_data == 8'h00) else $error("increment read not zero");
endmodule // apsf_top_asserts
bind apsf_top apsf_top_asserts u_apsf_top_asserts (.i_clock, .i_rst, .i_rd_strobe, .i_wr_strobe,
    .i_wr_data, .o_rd_data, .o_rd_valid, .o_addr_ptr, .i_fifo_word, .o_fifo_pop, .i_check_complete,
    .o_mode_onehot, .o_host_bus_fast, .o_wake_threshold_high, .o_lowpass_bypass,
    .o_highpass_bypass, .o_check_start, .o_check_finished_flag, .o_soft_reset);
`default_nettype wire

// ### dv/apsf_fifo_model.sv
`timescale 1ns/100ps
`default_nettype none
module apsf_fifo_model (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_pop,
    output logic      [15:0] o_word,
    output logic      [7:0]  o_pops
);
    // The head advances on the popping edge, so a late capture sees the next word.
    always_ff @(posedge i_clock) if (i_rst) o_pops <= 8'h00; else if (i_pop) o_pops <= o_pops + 8'h01;
    assign o_word = {8'hA0 + o_pops, 8'h5F - o_pops};
endmodule // apsf_fifo_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int SL = 20;
    logic clk, rst = 1, xs = 0, rs = 0, ws = 0, cc = 0, odr = 0;
    logic [7:0] ad = 8'h00, wd = 8'h00, rdd, ptr, pops, e;
    logic rv, pop, fast, thr, lp, hp, st, fl, sr, settled;
    logic [3:0] mo;
    logic [15:0] fw;
    logic [7:0] tbl [4] = '{8'hC4, 8'h29, 8'hBE, 8'h53};
    int n_fail = 0, n_compared = 0, cyc = 0;
    apsf_top #(.SETTLE_LONG_CYCLES(SL)) u_apsf_top (.i_clock(clk), .i_rst(rst), .i_xfer_start(xs),
        .i_xfer_addr(ad), .i_rd_strobe(rs), .i_wr_strobe(ws), .i_wr_data(wd), .o_rd_data(rdd),
        .o_rd_valid(rv), .o_addr_ptr(ptr), .i_fifo_word(fw), .o_fifo_pop(pop),
        .i_check_complete(cc), .i_odr_tick(odr), .o_mode_onehot(mo), .o_host_bus_fast(fast),
        .o_wake_threshold_high(thr), .o_lowpass_bypass(lp), .o_highpass_bypass(hp),
        .o_filter_settled(settled), .o_check_start(st), .o_check_finished_flag(fl),
        .o_soft_reset(sr));
    apsf_fifo_model u_apsf_fifo_model (.i_clock(clk), .i_rst(rst), .i_pop(pop), .o_word(fw),
        .o_pops(pops));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            wrap_up;
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobes stay up until the next call, so back-to-back reads never toggle a strobe twice.
    task automatic drv(input logic x, r, w, input logic [7:0] a, d);
        xs = x; rs = r; ws = w; ad = a; wd = d;
        @(negedge clk);
    endtask
    task automatic go(input logic [7:0] a);
        drv(1, 0, 0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, d);
        go(a);
        drv(0, 0, 1, a, d);
    endtask
    task automatic rd(input logic [7:0] exp, input string nm);
        drv(0, 1, 0, ad, 8'h00);
        chk(nm, {rv, rdd}, {1'b1, exp});
    endtask
    task automatic tick(input logic t);
        odr = t;
        drv(0, 0, 0, ad, 8'h00);
        odr = 1'b0;
        drv(0, 0, 0, ad, 8'h00);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        go(8'h3F);
        rd(8'h00, "power");
        rd(8'h00, "self test");
        rd(8'h00, "reset reg");
        chk("mode", mo, 4'h1);
        $display("test reset values done");
        foreach (tbl[i]) begin
            wr(8'h3F, tbl[i]);
            chk("mode", mo, 4'h1 << tbl[i][1:0]);
            chk("bits", {fast, thr, lp, hp}, {tbl[i][7], tbl[i][5], tbl[i][3:2]});
            go(8'h3F);
            rd(tbl[i] & 8'hBF, "power readback");
        end
        $display("test power control done");
        wr(8'h3F, 8'h03);
        repeat (SL - 1) drv(0, 0, 0, ad, 8'h00);
        chk("settle long early", settled, 1'b0);
        drv(0, 0, 0, ad, 8'h00);
        chk("settle long", settled, 1'b1);
        wr(8'h3F, 8'h13);
        repeat (3) tick(1'b1);
        chk("settle short early", settled, 1'b0);
        tick(1'b1);
        tick(1'b0);
        chk("settle short", settled, 1'b1);
        wr(8'h3F, 8'h00);
        chk("standby settle", settled, 1'b0);
        $display("test settling done");
        wr(8'h40, 8'h01);
        chk("check started", {st, fl}, 2'b10);
        cc = 1'b1;
        drv(0, 0, 0, ad, 8'h00);
        cc = 1'b0;
        drv(0, 0, 0, ad, 8'h00);
        go(8'h40);
        rd(8'h03, "check readback");
        wr(8'h40, 8'hFC);
        go(8'h40);
        rd(8'h00, "check cleared");
        $display("test self test done");
        go(8'h42);
        for (int i = 0; i < 6; i++) begin
            e = (i % 3 == 2) ? 8'h00 : (i % 3 == 0) ? 8'hA0 + i / 3 : 8'h5F - i / 3;
            rd(e, "fifo byte");
        end
        chk("fifo ptr", ptr, 8'h42);
        chk("pop count", pops, 8'h02);
        go(8'h41);
        rd(8'h00, "reset reg read");
        rd(8'h00, "increment read");
        chk("ptr past port", ptr, 8'h43);
        chk("no pop", pops, 8'h02);
        $display("test fifo port done");
        wr(8'h3F, 8'h8F);
        wr(8'h41, 8'h17);
        chk("wrong key", {sr, fast}, 2'b01);
        wr(8'h41, 8'h52);
        chk("key pulse", sr, 1'b1);
        drv(0, 0, 0, ad, 8'h00);
        chk("after reset", {fast, mo, ptr}, {1'b0, 4'h1, 8'h00});
        $display("test soft reset done");
        drv(0, 0, 0, ad, 8'h00);
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
